//--- pkg/adm_ctrl_pkg.sv
package adm_ctrl_pkg;
   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'hE1;
   localparam logic [15:0] CTRL_RESET = 16'hBDA0;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int SYL_LSB = 13;
   localparam int STEP_MAX_LSB = 11;
   localparam int STEP_MIN_BIT = 10;
   localparam int RUN_LSB = 8;
   localparam int EST_LSB = 5;
   localparam int ORDER_LSB = 3;
   localparam int ZERO_LSB = 1;
   localparam int HALF_ZERO_BIT = 0;
   // -------------------------------------------------------------
   // Step size limits and adaptation
   // -------------------------------------------------------------
   localparam logic [15:0] STEP_MAX_0 = 16'h2800;
   localparam logic [15:0] STEP_MAX_1 = 16'h1400;
   localparam logic [15:0] STEP_MAX_2 = 16'h0A00;
   localparam logic [15:0] STEP_MAX_3 = 16'h0500;
   localparam logic [15:0] STEP_MIN_CLR = 16'h0014;
   localparam logic [15:0] STEP_MIN_SET = 16'h000A;
   localparam logic [15:0] STEP_RESET = 16'h0014;
   localparam logic [2:0] RUN_BASE = 3'h3;
   localparam logic [3:0] SYL_SHIFT_BASE = 4'h5;
   localparam logic [2:0] RUN_CNT_MAX = 3'h7;
   // Time constant numerators, ms = num / (3 * kbps)
   localparam logic [12:0] SYL_NUM_BASE = 13'h0200;
   localparam logic [7:0] EST_NUM_BASE = 8'h10;
   localparam logic [5:0] ZERO_TC_X2_MAX = 6'h09;
endpackage

//--- hdl/adm_encoder_adaptation_control.sv
`timescale 1ns/1ns
module adm_encoder_adaptation_control (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic bit_strobe,
   input wire logic enc_bit,
   input wire logic decode_mode,
   output logic [15:0] ctrl_word,
   output logic signed [15:0] step_size,
   output logic [15:0] step_max,
   output logic [15:0] step_min,
   output logic [2:0] run_len,
   output logic run_hit,
   output logic [12:0] syl_tc_num,
   output logic [3:0] syl_shift,
   output logic [7:0] est_tc_num,
   output logic second_order,
   output logic [1:0] loss_shift,
   output logic zero_enable,
   output logic [5:0] zero_tc_x2,
   output logic half_rate_zero
);
   // -------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------
   // Codes step 1, 1.5, 2, 3, 4, 6, 8, 12 times the base
   function automatic logic [12:0] tc_scale(input logic [2:0] code, input logic [12:0] base);
      logic [12:0] whole;
      whole = base << code[2:1];
      tc_scale = code[0] ? 13'(whole + (whole >> 1)) : whole;
   endfunction

   function automatic logic [15:0] max_of(input logic [1:0] code);
      case (code)
         2'h0: max_of = adm_ctrl_pkg::STEP_MAX_0;
         2'h1: max_of = adm_ctrl_pkg::STEP_MAX_1;
         2'h2: max_of = adm_ctrl_pkg::STEP_MAX_2;
         default: max_of = adm_ctrl_pkg::STEP_MAX_3;
      endcase
   endfunction

   // -------------------------------------------------------------
   // Control word
   // -------------------------------------------------------------
   logic [15:0] ctrl_ff;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff <= adm_ctrl_pkg::CTRL_RESET;
      end else if (wr_en && wr_addr == adm_ctrl_pkg::CTRL_ADDR) begin
         ctrl_ff <= wr_data;
      end
   end

   assign ctrl_word = ctrl_ff;

   logic [2:0] syl_code;
   logic [2:0] est_code;
   logic [1:0] order_code;
   logic [1:0] zero_code;
   assign syl_code = ctrl_ff[adm_ctrl_pkg::SYL_LSB +: 3];
   assign est_code = ctrl_ff[adm_ctrl_pkg::EST_LSB +: 3];
   assign order_code = ctrl_ff[adm_ctrl_pkg::ORDER_LSB +: 2];
   assign zero_code = ctrl_ff[adm_ctrl_pkg::ZERO_LSB +: 2];

   assign syl_tc_num = tc_scale(syl_code, adm_ctrl_pkg::SYL_NUM_BASE);
   // Longer syllabic constant, slower leak of the step integrator
   assign syl_shift = 4'(adm_ctrl_pkg::SYL_SHIFT_BASE + {1'b0, syl_code});
   assign step_max = max_of(ctrl_ff[adm_ctrl_pkg::STEP_MAX_LSB +: 2]);
   assign step_min = ctrl_ff[adm_ctrl_pkg::STEP_MIN_BIT] ? adm_ctrl_pkg::STEP_MIN_SET
                                                       : adm_ctrl_pkg::STEP_MIN_CLR;
   assign run_len = 3'(adm_ctrl_pkg::RUN_BASE
      + {1'b0, ctrl_ff[adm_ctrl_pkg::RUN_LSB +: 2]});
   assign est_tc_num = 8'(tc_scale(est_code, {5'h00, adm_ctrl_pkg::EST_NUM_BASE}));
   assign second_order = order_code != 2'h0;
   assign loss_shift = order_code;
   // Zero time constant in half units: code 3 gives 4.5 / kbps
   assign zero_enable = second_order && zero_code != 2'h0;
   assign zero_tc_x2 = zero_enable ? 6'(adm_ctrl_pkg::ZERO_TC_X2_MAX * zero_code / 3) : 6'h00;
   // Only honoured while decoding; encoder loop would go unstable
   assign half_rate_zero = ctrl_ff[adm_ctrl_pkg::HALF_ZERO_BIT] && decode_mode;

   // -------------------------------------------------------------
   // Run detector
   // -------------------------------------------------------------
   // Count saturates so a long run keeps adapting without wrapping
   logic [2:0] run_cnt_ff;
   logic last_bit_ff;
   logic [2:0] nxt_run_cnt;

   always_comb begin
      if (enc_bit != last_bit_ff || run_cnt_ff == 3'h0) begin
         nxt_run_cnt = 3'h1;
      end else if (run_cnt_ff == adm_ctrl_pkg::RUN_CNT_MAX) begin
         nxt_run_cnt = run_cnt_ff;
      end else begin
         nxt_run_cnt = run_cnt_ff + 3'h1;
      end
   end

   assign run_hit = bit_strobe && nxt_run_cnt >= run_len;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         run_cnt_ff <= 3'h0;
         last_bit_ff <= 1'b0;
      end else if (bit_strobe) begin
         run_cnt_ff <= nxt_run_cnt;
         last_bit_ff <= enc_bit;
      end
   end

   // -------------------------------------------------------------
   // Step size integrator
   // -------------------------------------------------------------
   logic signed [15:0] step_ff;
   logic signed [17:0] nxt_step;
   logic signed [17:0] cur;
   logic signed [17:0] hi;
   logic signed [17:0] lo;

   always_comb begin
      cur = 18'(step_ff);
      hi = {2'b00, step_max};
      lo = {2'b00, step_min};
      if (run_hit) begin
         nxt_step = cur + ((hi - cur) >>> syl_shift) + 18'sh1;
      end else begin
         nxt_step = cur - (cur >>> syl_shift);
      end
      // Clamp on the 16-bit scale at the selected limits
      if (nxt_step > hi) begin
         nxt_step = hi;
      end else if (nxt_step < lo) begin
         nxt_step = lo;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         step_ff <= adm_ctrl_pkg::STEP_RESET;
      end else if (bit_strobe) begin
         step_ff <= 16'(nxt_step);
      end
   end

   assign step_size = step_ff;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_word_capture: assert property (
      wr_en && wr_addr == adm_ctrl_pkg::CTRL_ADDR |=> ctrl_word == $past(wr_data))
      else $error("control word not captured");
   a_word_holds: assert property (
      !(wr_en && wr_addr == adm_ctrl_pkg::CTRL_ADDR) |=> $stable(ctrl_word))
      else $error("control word changed without write");
   a_step_range: assert property (
      bit_strobe ##1 $stable(ctrl_word) |-> step_size <= $signed({1'b0, step_max[14:0]})
         && step_size >= $signed({1'b0, step_min[14:0]}))
      else $error("step outside limits");
   a_step_grows: assert property (
      run_hit && step_size < $signed(step_max)
         |=> step_size > $past(step_size))
      else $error("step did not grow on run");
   a_step_decays: assert property (
      bit_strobe && !run_hit |=> step_size <= $past(step_size)
         || step_size == $signed($past(step_min)))
      else $error("step grew without run");
   a_run_length: assert property (
      run_len == 3'(ctrl_word[9:8]) + 3'h3)
      else $error("run length decode wrong");
   a_max_decode: assert property (
      ctrl_word[12:11] == 2'h3 |-> step_max == 16'h0500)
      else $error("max step decode wrong");
   a_syl_decode: assert property (
      ctrl_word[15:13] == 3'h7 |-> syl_tc_num == 13'h1800)
      else $error("syllabic decode wrong");
   a_est_decode: assert property (
      ctrl_word[7:5] == 3'h5 |-> est_tc_num == 8'h60)
      else $error("estimator decode wrong");
   a_order_zero: assert property (
      ctrl_word[4:3] == 2'h0 |-> !second_order && !zero_enable && zero_tc_x2 == 6'h00)
      else $error("zero active in first order");
   a_half_zero: assert property (
      half_rate_zero == (ctrl_word[0] && decode_mode))
      else $error("half rate zero wrong");
   a_min_decode: assert property (
      step_min == (ctrl_word[10] ? 16'h000A : 16'h0014))
      else $error("min step decode wrong");
   a_zero_time: assert property (
      zero_enable && ctrl_word[2:1] == 2'h3 |-> zero_tc_x2 == 6'h09)
      else $error("zero time decode wrong");
   a_run_break: assert property (
      bit_strobe && enc_bit != last_bit_ff |-> !run_hit)
      else $error("run hit on changed bit");

   // -------------------------------------------------------------
   // Coverage
   // -------------------------------------------------------------
   c_run_hit: cover property (run_hit ##1 bit_strobe && run_hit);
   c_step_max: cover property (bit_strobe ##1 step_size == $signed(step_max));
   c_rewrite: cover property (wr_en && wr_addr == adm_ctrl_pkg::CTRL_ADDR ##[1:20] run_hit);
   c_second_order: cover property (second_order && zero_tc_x2 == 6'h09);
   c_step_leak: cover property (bit_strobe && !run_hit ##1 step_size < $past(step_size));
endmodule

//--- bench/host_model.sv
`timescale 1ns/1ns
module host_model (
   input wire logic core_clk,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [15:0] wr_data
);
   initial begin
      wr_en = 1'b0;
      wr_addr = 8'h00;
      wr_data = 16'h0000;
   end
   // One word per write, bit 0 cleared unless dec is set; bus pattern flips once released
   task automatic write(input logic [7:0] a, input logic [15:0] d, input logic dec);
      @(posedge core_clk);
      #1;
      wr_en = 1'b1;
      wr_addr = a;
      wr_data = dec ? d : {d[15:1], 1'b0};
      @(posedge core_clk);
      #1;
      wr_en = 1'b0;
      wr_addr = ~wr_addr;
      wr_data = ~wr_data;
   endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic core_clk, rstn, bit_strobe, enc_bit, decode_mode, wr_en, run_hit, second_order;
   logic half_rate_zero, zero_enable, h, ok;
   logic m_last = 1'b0;
   logic [2:0] m_cnt = 3'h0;
   logic signed [15:0] m_step = 16'sh0014;
   logic [31:0] r;
   logic [7:0] wr_addr, est_tc_num;
   logic [15:0] wr_data, ctrl_word, step_max, step_min, w, exp_w;
   logic signed [15:0] step_size, prev;
   logic [2:0] run_len;
   logic [12:0] syl_tc_num;
   logic [3:0] syl_shift;
   logic [1:0] loss_shift;
   logic [5:0] zero_tc_x2;
   logic [31:0] seed = 32'hE7E5;
   int miscompares = 0, num_checks = 0, cycles = 0;
   host_model host_u (.core_clk(core_clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
   adm_encoder_adaptation_control dut_u (.core_clk(core_clk), .rstn(rstn), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data), .bit_strobe(bit_strobe), .enc_bit(enc_bit),
      .decode_mode(decode_mode), .ctrl_word(ctrl_word), .step_size(step_size),
      .step_max(step_max), .step_min(step_min), .run_len(run_len), .run_hit(run_hit),
      .syl_tc_num(syl_tc_num), .syl_shift(syl_shift), .est_tc_num(est_tc_num),
      .second_order(second_order), .loss_shift(loss_shift), .zero_enable(zero_enable),
      .zero_tc_x2(zero_tc_x2), .half_rate_zero(half_rate_zero));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Step law: grow toward the ceiling on a run, leak otherwise, clamp
   function automatic logic signed [15:0] exp_step(input logic signed [15:0] s,
      input logic hit, input logic [15:0] x);
      logic [15:0] mx [4] = '{16'h2800, 16'h1400, 16'h0A00, 16'h0500};
      logic signed [17:0] c, hi, lo, n;
      logic [3:0] sh;
      sh = 4'(x[15:13]) + 4'h5;
      c = 18'(s);
      hi = $signed({2'b00, mx[x[12:11]]});
      lo = x[10] ? 18'sh0000A : 18'sh00014;
      n = hit ? c + ((hi - c) >>> sh) + 18'sh1 : c - (c >>> sh);
      if (n > hi)
         n = hi;
      else if (n < lo)
         n = lo;
      return 16'(n);
   endfunction
   task automatic check_cfg(input logic [15:0] x, input logic dm);
      logic [12:0] syl [8] = '{13'h0200, 13'h0300, 13'h0400, 13'h0600, 13'h0800, 13'h0C00,
         13'h1000, 13'h1800};
      logic [7:0] est [8] = '{8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80, 8'hC0};
      logic [15:0] mx [4] = '{16'h2800, 16'h1400, 16'h0A00, 16'h0500};
      logic z;
      z = (x[4:3] != 2'h0) && (x[2:1] != 2'h0);
      chk(ctrl_word, x);
      chk(16'(syl_tc_num), 16'(syl[x[15:13]]));
      chk(16'(syl_shift), 16'(x[15:13]) + 16'h0005);
      chk(step_max, mx[x[12:11]]);
      chk(step_min, x[10] ? 16'h000A : 16'h0014);
      chk(16'(run_len), 16'(x[9:8]) + 16'h0003);
      chk(16'(est_tc_num), 16'(est[x[7:5]]));
      chk({15'h0, second_order}, {15'h0, x[4:3] != 2'h0});
      chk(16'(loss_shift), 16'(x[4:3]));
      chk({15'h0, zero_enable}, {15'h0, z});
      chk(16'(zero_tc_x2), z ? 16'(x[2:1]) * 16'h0003 : 16'h0000);
      chk({15'h0, half_rate_zero}, {15'h0, x[0] & dm});
   endtask
   task automatic strobe(input logic b);
      logic hit;
      @(posedge core_clk);
      #1;
      bit_strobe = 1'b1;
      enc_bit = b;
      m_cnt = (b != m_last || m_cnt == 3'h0) ? 3'h1 : m_cnt + 3'(m_cnt != 3'h7);
      m_last = b;
      hit = m_cnt >= 3'(exp_w[9:8]) + 3'h3;
      m_step = exp_step(m_step, hit, exp_w);
      #1;
      h = run_hit;
      chk({15'h0, h}, {15'h0, hit});
      @(posedge core_clk);
      #1;
      bit_strobe = 1'b0;
      chk(step_size, m_step);
   endtask
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         wrap_up();
      end
   end
   initial begin
      {rstn, bit_strobe, enc_bit, decode_mode} = 4'h0;
      repeat (16) @(posedge core_clk);
      #1 rstn = 1'b1;
      exp_w = 16'hBDA0;
      check_cfg(exp_w, 1'b0);
      chk(step_size, 16'h0014);
      for (int i = 0; i < 48; i++) begin
         w = rnd();
         // Across the write to 8'hE2, decode level stays up while the held word still has bit 0 set
         if (i % 8 != 7 || !exp_w[0])
            decode_mode = w[5] ^ w[9];
         host_u.write((i % 8 == 7) ? 8'hE2 : 8'hE1, w, decode_mode);
         if (i % 8 != 7)
            exp_w = decode_mode ? w : {w[15:1], 1'b0};
         check_cfg(exp_w, decode_mode);
         r = rnd();
         for (int j = 0; j < 6; j++)
            strobe(r[j]);
      end
      decode_mode = 1'b0;
      for (int rc = 0; rc < 4; rc++) begin
         w = rnd();
         exp_w = {w[15:10], 2'(rc), w[7:1], 1'b0};
         host_u.write(8'hE1, exp_w, 1'b0);
         strobe(1'b0);
         for (int k = 1; k <= rc + 3; k++) begin
            prev = step_size;
            strobe(1'b1);
            chk({15'h0, h}, {15'h0, k == rc + 3});
            ok = step_size >= $signed(step_min) && step_size <= $signed(step_max);
            chk({15'h0, ok}, 16'h0001);
         end
         chk({15'h0, step_size > prev || step_size == $signed(step_max)}, 16'h0001);
      end
      // Long run of ones climbs onto the lowest ceiling
      exp_w = 16'h1800;
      host_u.write(8'hE1, exp_w, 1'b0);
      check_cfg(exp_w, 1'b0);
      repeat (200) strobe(1'b1);
      chk(step_size, 16'h0500);
      // Alternating bits never complete a run, so the step only leaks
      for (int k = 0; k < 40; k++)
         strobe(k[0]);
      chk({15'h0, step_size < 16'sh0500}, 16'h0001);
      // Reset in mid-run restores the profile word and the 0x0014 reset step
      rstn = 1'b0;
      #2;
      check_cfg(16'hBDA0, 1'b0);
      chk(step_size, 16'h0014);
      repeat (3) @(posedge core_clk);
      #1 rstn = 1'b1;
      exp_w = 16'hBDA0;
      m_cnt = 3'h0;
      m_last = 1'b0;
      m_step = 16'sh0014;
      repeat (5) strobe(1'b0);
      wrap_up();
   end
endmodule
